// [rsq_defs.svh]
`ifndef RSQ_DEFS_SVH
`define RSQ_DEFS_SVH
// word indices, byte address is four times the index
`define RSQ_IDX_RX_CFG 6'h37
`define RSQ_IDX_TIMER_RES 6'h38
`define RSQ_IDX_T1_COEF 6'h39
`define RSQ_IDX_CTRL 6'h3c
`define RSQ_IDX_STATE 6'h3d
`define RSQ_IDX_IRQ_ST 6'h3e
`define RSQ_IDX_IRQ_MASK 6'h3f
`define RSQ_RXEX_MSB 7
`define RSQ_RXEX_LSB 5
`define RSQ_RXTO_MSB 4
`define RSQ_RXTO_LSB 3
`define RSQ_PKT_MSB 2
`define RSQ_PKT_LSB 0
`define RSQ_T1RES_MSB 3
`define RSQ_T1RES_LSB 2
`define RSQ_T2RES_MSB 1
`define RSQ_T2RES_LSB 0
`define RSQ_CTRL_START 7
`define RSQ_CTRL_STOP 6
`define RSQ_CTRL_LP_IDLE 2
`define RSQ_CTRL_IDLE_RX 1
`define RSQ_IRQ_XFER 0
`define RSQ_IRQ_RXTO 1
`define RSQ_IRQ_T1 2
`define RSQ_RXEX_PKT_PAYLOAD 3'h1
`define RSQ_RXEX_LP_PAYLOAD 3'h2
`define RSQ_RXEX_PKT_CRC 3'h3
`define RSQ_RXEX_OFF_RSSI 3'h4
`define RSQ_RXEX_OFF_SYNC 3'h5
`define RSQ_RXEX_OFF_PRE 3'h6
`define RSQ_RXTO_RESTART 2'h0
`define RSQ_RXTO_TX 2'h1
`define RSQ_RXTO_LP 2'h2
`define RSQ_RXTO_OFF 2'h3
`define RSQ_PKT_OFF 3'h0
`define RSQ_PKT_TX_EMPTY 3'h1
`define RSQ_PKT_LP 3'h2
`define RSQ_PKT_RX_FS 3'h3
`define RSQ_PKT_RX 3'h4
`define RSQ_RST_RX_CFG 8'h00
`define RSQ_RST_TIMER_RES 8'h00
`define RSQ_RST_T1_COEF 8'hf5
`define RSQ_RST_CTRL 8'h00
`define RSQ_RST_IRQ 8'h00
`define RSQ_CLK_MHZ 20
`define RSQ_TICK1_US 64
`define RSQ_TICK2_US 4100
`define RSQ_TICK3_US 262000
`define RSQ_CYC(us) ((us) * `RSQ_CLK_MHZ)
`endif

// [rsq_pkg.sv]
package rsq_pkg;
  typedef enum logic [2:0] {
    RSQ_OFF  = 3'h0,
    RSQ_RX   = 3'h1,
    RSQ_PKT  = 3'h3,
    RSQ_FS   = 3'h2,
    RSQ_TX   = 3'h6,
    RSQ_IDLE = 3'h7
  } rsq_state_e;

  typedef struct packed {
    logic payload_complete_irq;
    logic checksum_pass_irq;
    logic strength_irq;
    logic sync_match_irq;
    logic preamble_found_irq;
    logic strength_wait_expired;
    logic preamble_wait_expired;
    logic sync_wait_expired;
    logic queue_drained_irq;
    logic packet_sent_irq;
    logic synth_locked;
  } rsq_rx_irq_s;
endpackage : rsq_pkg

// [rsq_timer.sv]
`timescale 1ns/1ps
`include "rsq_defs.svh"
module rsq_timer #(
  parameter logic [22:0] TICK2_CYC = 23'(`RSQ_CYC(`RSQ_TICK2_US)),
  parameter logic [22:0] TICK3_CYC = 23'(`RSQ_CYC(`RSQ_TICK3_US))
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] tick_sel,
  input wire logic [7:0] coef,
  output logic expire
);
  localparam logic [22:0] TICK1_CYC = 23'(`RSQ_CYC(`RSQ_TICK1_US));

  function automatic logic [22:0] tick_len(input logic [1:0] sel);
    case (sel)
      2'h1: tick_len = TICK1_CYC;
      2'h2: tick_len = TICK2_CYC;
      default: tick_len = TICK3_CYC;
    endcase
  endfunction : tick_len

  logic [22:0] div_r;
  logic [7:0] cnt_r;
  logic expire_r;
  wire active = run && (tick_sel != 2'h0);
  wire tick = active && (div_r == tick_len(tick_sel) - 23'h1);
  // coefficient zero behaves as one tick rather than never firing
  wire last_tick = tick && (cnt_r + 8'h1 >= coef);

  always_ff @(posedge clk) begin
    if (!rst_n || !active) begin
      div_r <= 23'h0;
      cnt_r <= 8'h0;
      expire_r <= 1'b0;
    end else begin
      div_r <= tick ? 23'h0 : div_r + 23'h1;
      cnt_r <= last_tick ? 8'h0 : (tick ? cnt_r + 8'h1 : cnt_r);
      expire_r <= last_tick;
    end
  end
  assign expire = expire_r;
endmodule : rsq_timer

// [rsq_seq_rx.sv]
// Functional notes
// (RULE1) receive exit 001 to packet state, 010 to low power, on payload ready
// (RULE2) receive exit 011 goes to packet state only on checksum pass
// (RULE3) receive exit 100/101/110 halt on strength, sync match, preamble found
// (RULE4) software never programs receive exit 000 or 111; they do nothing
// (RULE5) timeout field: 00 relaunch receive, 01 transmit, 10 low power, 11 halt
// (RULE6) with exit 011 a payload ready without checksum takes the timeout path
// (RULE7) any of three wait expiries counts as the receive timeout
// (RULE8) packet exit 000 halt, 001 transmit on queue drained, 010 low power
// (RULE9) packet exit 011 back to receive via synthesizer if retuned, 100 direct
// (RULE10) timer one tick select: off, 64 us, 4.1 ms, 262 ms
// (RULE11) low power choice halts, or enters idle, per control bit
// (RULE12) timer one period is tick times coefficient, reset 0xf5, wakes idle
// (RULE13) all transition fields reset to zero; 110 means preamble found
// (RULE14) events count only in their own state, one transition each
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "rsq_defs.svh"
module rsq_seq_rx #(
  parameter logic [22:0] TICK2_CYC = 23'(`RSQ_CYC(`RSQ_TICK2_US)),
  parameter logic [22:0] TICK3_CYC = 23'(`RSQ_CYC(`RSQ_TICK3_US))
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input rsq_pkg::rsq_rx_irq_s rx_irq,
  input wire logic freq_changed,
  output rsq_pkg::rsq_state_e seq_state,
  output logic reception_relaunch,
  output logic first_timer_expiry,
  output logic irq
);
  import rsq_pkg::*;

  logic [7:0] rx_cfg_r;
  logic [7:0] timer_res_r;
  logic [7:0] t1_coef_r;
  logic [7:0] ctrl_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_mask_r;
  logic [31:0] dat_r;
  logic ack_r;
  logic relaunch_r;
  rsq_state_e state_r;
  rsq_state_e state_nxt;
  logic relaunch_nxt;

  // bus decode
  wire [5:0] idx = wb_adr_i[7:2];
  wire req = wb_cyc_i && wb_stb_i;
  wire wr_en = req && wb_we_i && ack_r && wb_sel_i[0];
  wire rd_done = req && !wb_we_i && ack_r;
  wire [7:0] wdat = wb_dat_i[7:0];
  wire wr_rx_cfg = wr_en && (idx == `RSQ_IDX_RX_CFG);
  wire wr_timer_res = wr_en && (idx == `RSQ_IDX_TIMER_RES);
  wire wr_t1_coef = wr_en && (idx == `RSQ_IDX_T1_COEF);
  wire wr_ctrl = wr_en && (idx == `RSQ_IDX_CTRL);
  wire wr_mask = wr_en && (idx == `RSQ_IDX_IRQ_MASK);
  wire rd_irq_st = rd_done && (idx == `RSQ_IDX_IRQ_ST);
  wire start_req = wr_ctrl && wdat[`RSQ_CTRL_START];
  wire stop_req = wr_ctrl && wdat[`RSQ_CTRL_STOP];

  // register fields
  wire [2:0] rx_exit = rx_cfg_r[`RSQ_RXEX_MSB:`RSQ_RXEX_LSB];
  wire [1:0] rxto_exit = rx_cfg_r[`RSQ_RXTO_MSB:`RSQ_RXTO_LSB];
  wire [2:0] pkt_exit = rx_cfg_r[`RSQ_PKT_MSB:`RSQ_PKT_LSB];
  wire [1:0] t1_sel = timer_res_r[`RSQ_T1RES_MSB:`RSQ_T1RES_LSB];
  wire lp_idle = ctrl_r[`RSQ_CTRL_LP_IDLE];
  wire idle_to_rx = ctrl_r[`RSQ_CTRL_IDLE_RX];

  // event decode
  wire rx_timeout = rx_irq.strength_wait_expired || rx_irq.preamble_wait_expired ||
                    rx_irq.sync_wait_expired; // RULE7
  wire payload = rx_irq.payload_complete_irq;
  wire crc_ok = rx_irq.checksum_pass_irq;
  wire exit_to_pkt = ((rx_exit == `RSQ_RXEX_PKT_PAYLOAD) && payload) ||
                     ((rx_exit == `RSQ_RXEX_PKT_CRC) && crc_ok); // RULE1 RULE2
  wire exit_to_lp = (rx_exit == `RSQ_RXEX_LP_PAYLOAD) && payload; // RULE1
  // 110 is preamble found; codes 000 and 111 fall through with no event
  wire exit_to_off = ((rx_exit == `RSQ_RXEX_OFF_RSSI) && rx_irq.strength_irq) ||
                     ((rx_exit == `RSQ_RXEX_OFF_SYNC) && rx_irq.sync_match_irq) ||
                     ((rx_exit == `RSQ_RXEX_OFF_PRE) && rx_irq.preamble_found_irq); // RULE3 RULE13 RULE4
  // checksum pass wins when it comes with payload ready
  wire crc_fail = (rx_exit == `RSQ_RXEX_PKT_CRC) && payload && !crc_ok; // RULE6
  wire rx_exit_evt = exit_to_pkt || exit_to_lp || exit_to_off;
  wire rxto_evt = !rx_exit_evt && (rx_timeout || crc_fail); // RULE6
  wire t1_expire;

  function automatic rsq_state_e lp_dest(input logic to_idle);
    lp_dest = to_idle ? RSQ_IDLE : RSQ_OFF; // RULE11
  endfunction : lp_dest

  function automatic rsq_state_e rxto_dest(input logic [1:0] code, input logic to_idle);
    case (code)
      `RSQ_RXTO_RESTART: rxto_dest = RSQ_RX;
      `RSQ_RXTO_TX: rxto_dest = RSQ_TX;
      `RSQ_RXTO_LP: rxto_dest = lp_dest(to_idle);
      default: rxto_dest = RSQ_OFF;
    endcase
  endfunction : rxto_dest

  // each state watches only its own events; stop overrides everything
  always_comb begin
    state_nxt = state_r;
    relaunch_nxt = 1'b0;
    case (state_r) // RULE14
      RSQ_OFF: begin
        if (start_req) begin
          state_nxt = RSQ_RX;
        end
      end
      RSQ_RX: begin
        if (exit_to_pkt) begin
          state_nxt = RSQ_PKT;
        end else if (exit_to_lp) begin
          state_nxt = lp_dest(lp_idle);
        end else if (exit_to_off) begin
          state_nxt = RSQ_OFF;
        end else if (rxto_evt) begin
          state_nxt = rxto_dest(rxto_exit, lp_idle); // RULE5
          relaunch_nxt = (rxto_exit == `RSQ_RXTO_RESTART); // RULE5
        end
      end
      RSQ_PKT: begin
        case (pkt_exit) // RULE8 RULE9
          `RSQ_PKT_OFF: state_nxt = RSQ_OFF;
          `RSQ_PKT_TX_EMPTY: state_nxt = rx_irq.queue_drained_irq ? RSQ_TX : RSQ_PKT;
          `RSQ_PKT_LP: state_nxt = lp_dest(lp_idle);
          `RSQ_PKT_RX_FS: state_nxt = freq_changed ? RSQ_FS : RSQ_RX;
          `RSQ_PKT_RX: state_nxt = RSQ_RX;
          default: state_nxt = RSQ_PKT;
        endcase
      end
      RSQ_FS: begin
        if (rx_irq.synth_locked) begin
          state_nxt = RSQ_RX;
        end
      end
      RSQ_TX: begin
        if (rx_irq.packet_sent_irq) begin
          state_nxt = lp_dest(lp_idle);
        end
      end
      RSQ_IDLE: begin
        if (t1_expire) begin
          state_nxt = idle_to_rx ? RSQ_RX : RSQ_TX; // RULE12
        end
      end
      default: state_nxt = RSQ_OFF;
    endcase
    if (stop_req) begin
      state_nxt = RSQ_OFF;
      relaunch_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= RSQ_OFF;
      relaunch_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      relaunch_r <= relaunch_nxt;
    end
  end

  // timer one only runs while idling, so a stale count never wakes another state
  rsq_timer #(
    .TICK2_CYC(TICK2_CYC),
    .TICK3_CYC(TICK3_CYC)
  ) u_timer1 (
    .clk(clk),
    .rst_n(rst_n),
    .run(state_r == RSQ_IDLE),
    .tick_sel(t1_sel), // RULE10
    .coef(t1_coef_r), // RULE12
    .expire(t1_expire)
  );

  // configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_cfg_r <= `RSQ_RST_RX_CFG; // RULE13
      timer_res_r <= `RSQ_RST_TIMER_RES;
      t1_coef_r <= `RSQ_RST_T1_COEF; // RULE12
      ctrl_r <= `RSQ_RST_CTRL;
      irq_mask_r <= 3'(`RSQ_RST_IRQ);
    end else begin
      if (wr_rx_cfg) rx_cfg_r <= wdat;
      if (wr_timer_res) timer_res_r <= {4'h0, wdat[3:0]};
      if (wr_t1_coef) t1_coef_r <= wdat;
      // start and stop are strobes and never stored
      if (wr_ctrl) ctrl_r <= {2'h0, wdat[5:0]};
      if (wr_mask) irq_mask_r <= wdat[2:0];
    end
  end

  // sticky events; a new event beats the clearing read
  // the read clears only the bits it returned, so an event after the capture is kept
  wire xfer_evt = (state_nxt != state_r) || relaunch_nxt;
  wire [2:0] irq_evt = {t1_expire, rxto_evt && (state_r == RSQ_RX), xfer_evt};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_st_r <= 3'(`RSQ_RST_IRQ);
    end else begin
      irq_st_r <= (rd_irq_st ? (irq_st_r & ~dat_r[2:0]) : irq_st_r) | irq_evt;
    end
  end

  // read mux
  logic [7:0] rd_mux;
  always_comb begin
    case (idx)
      `RSQ_IDX_RX_CFG: rd_mux = rx_cfg_r;
      `RSQ_IDX_TIMER_RES: rd_mux = timer_res_r;
      `RSQ_IDX_T1_COEF: rd_mux = t1_coef_r;
      `RSQ_IDX_CTRL: rd_mux = ctrl_r;
      `RSQ_IDX_STATE: rd_mux = {5'h0, state_r};
      `RSQ_IDX_IRQ_ST: rd_mux = {5'h0, irq_st_r};
      `RSQ_IDX_IRQ_MASK: rd_mux = {5'h0, irq_mask_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // one-cycle ack, dropped the cycle after it was given
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req && !ack_r;
      if (req && !ack_r) dat_r <= {24'h0, rd_mux};
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign seq_state = state_r;
  assign reception_relaunch = relaunch_r;
  assign first_timer_expiry = t1_expire;
  assign irq = |(irq_st_r & irq_mask_r);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire in_rx = (state_r == RSQ_RX) && !stop_req;
  wire in_pkt = (state_r == RSQ_PKT) && !stop_req;

  payload_pkt_a: assert property ( // RULE1
    in_rx && rx_exit == 3'h1 && payload |=> state_r == RSQ_PKT)
    else $error("payload ready did not reach packet state");
  payload_lp_a: assert property ( // RULE1
    in_rx && rx_exit == 3'h2 && payload |=> state_r == ($past(lp_idle) ? RSQ_IDLE : RSQ_OFF))
    else $error("payload ready did not reach low power");
  crc_exit_a: assert property ( // RULE2
    in_rx && rx_exit == 3'h3 && crc_ok |=> state_r == RSQ_PKT)
    else $error("checksum pass did not reach packet state");
  preamble_off_a: assert property ( // RULE3
    in_rx && rx_exit == 3'h6 && rx_irq.preamble_found_irq |=> state_r == RSQ_OFF)
    else $error("preamble found did not halt");
  unused_code_a: assert property ( // RULE4
    in_rx && (rx_exit == 3'h0 || rx_exit == 3'h7) && !rx_timeout |=> state_r == RSQ_RX)
    else $error("unused exit code moved the sequencer");
  restart_pulse_a: assert property ( // RULE5
    in_rx && rxto_exit == 2'h0 && rxto_evt |=> reception_relaunch && state_r == RSQ_RX
    ##1 !reception_relaunch)
    else $error("timeout restart pulse wrong");
  crc_fail_a: assert property ( // RULE6
    in_rx && rx_exit == 3'h3 && payload && !crc_ok && rxto_exit == 2'h1 |=> state_r == RSQ_TX)
    else $error("failed checksum did not take timeout path");
  sync_timeout_a: assert property ( // RULE7
    in_rx && rx_exit == 3'h4 && !rx_irq.strength_irq && rx_irq.sync_wait_expired &&
    rxto_exit == 2'h3 |=> state_r == RSQ_OFF)
    else $error("sync wait expiry not treated as timeout");
  fifo_tx_a: assert property ( // RULE8
    in_pkt && pkt_exit == 3'h1 |=> state_r == ($past(rx_irq.queue_drained_irq) ? RSQ_TX : RSQ_PKT))
    else $error("queue drained transition wrong");
  retune_fs_a: assert property ( // RULE9
    in_pkt && pkt_exit == 3'h3 |=> state_r == ($past(freq_changed) ? RSQ_FS : RSQ_RX))
    else $error("retune path wrong");
  timer_off_a: assert property ( // RULE10
    t1_sel == 2'h0 |-> !t1_expire)
    else $error("disabled timer one expired");
  coef_reset_a: assert property ( // RULE12
    $rose(rst_n) |-> t1_coef_r == 8'hf5 && rx_cfg_r == 8'h00)
    else $error("reset values wrong");
  idle_wake_a: assert property ( // RULE14
    state_r != RSQ_IDLE |=> !t1_expire)
    else $error("timer one expired outside idle");
  strength_off_a: assert property ( // RULE3
    in_rx && rx_exit == 3'h4 && rx_irq.strength_irq |=> state_r == RSQ_OFF)
    else $error("strength event did not halt");
  sync_off_a: assert property ( // RULE3
    in_rx && rx_exit == 3'h5 && rx_irq.sync_match_irq |=> state_r == RSQ_OFF)
    else $error("sync match did not halt");
  timeout_tx_a: assert property ( // RULE5 RULE7
    in_rx && rx_exit == 3'h4 && !rx_irq.strength_irq && rx_irq.preamble_wait_expired &&
    rxto_exit == 2'h1 |=> state_r == RSQ_TX)
    else $error("preamble wait expiry did not reach transmit");
  pkt_off_a: assert property ( // RULE8
    in_pkt && pkt_exit == 3'h0 |=> state_r == RSQ_OFF)
    else $error("packet exit halt wrong");
  pkt_lp_a: assert property ( // RULE8 RULE11
    in_pkt && pkt_exit == 3'h2 |=> state_r == ($past(lp_idle) ? RSQ_IDLE : RSQ_OFF))
    else $error("packet exit low power wrong");
  pkt_direct_a: assert property ( // RULE9
    in_pkt && pkt_exit == 3'h4 |=> state_r == RSQ_RX)
    else $error("direct return to receive wrong");
  idle_exit_a: assert property ( // RULE12
    state_r == RSQ_IDLE && t1_expire && !stop_req
    |=> state_r == ($past(idle_to_rx) ? RSQ_RX : RSQ_TX))
    else $error("idle exit on timer one wrong");
  relaunch_rx_a: assert property ( // RULE5
    reception_relaunch |-> state_r == RSQ_RX)
    else $error("relaunch pulse outside receive");
  fs_lock_a: assert property (
    state_r == RSQ_FS && rx_irq.synth_locked && !stop_req |=> state_r == RSQ_RX)
    else $error("synthesizer lock did not return to receive");
  tx_sent_a: assert property (
    state_r == RSQ_TX && rx_irq.packet_sent_irq && !stop_req
    |=> state_r == ($past(lp_idle) ? RSQ_IDLE : RSQ_OFF))
    else $error("packet sent did not reach low power");
  stop_wins_a: assert property (
    stop_req |=> state_r == RSQ_OFF)
    else $error("stop strobe did not halt");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  status_set_a: assert property (
    xfer_evt |=> irq_st_r[0])
    else $error("transition did not set status");

  rx_to_pkt_c: cover property (state_r == RSQ_RX ##1 state_r == RSQ_PKT);
  restart_c: cover property (reception_relaunch);
  idle_wake_c: cover property (state_r == RSQ_IDLE && t1_expire);
  fs_path_c: cover property (state_r == RSQ_FS ##1 state_r == RSQ_RX);
  crc_tx_c: cover property (state_r == RSQ_RX ##1 state_r == RSQ_TX);
endmodule : rsq_seq_rx

// [rsq_seq_rx_test.sv]
`timescale 1ns/1ps
`include "rsq_defs.svh"
module rsq_seq_rx_test;
  import rsq_pkg::*;
  localparam logic [10:0] M_PAY = 11'h400;
  localparam logic [10:0] M_CRC = 11'h200;
  localparam logic [10:0] M_STR = 11'h100;
  localparam logic [10:0] M_SYN = 11'h080;
  localparam logic [10:0] M_PRE = 11'h040;
  localparam logic [10:0] M_SW = 11'h020;
  localparam logic [10:0] M_PW = 11'h010;
  localparam logic [10:0] M_YW = 11'h008;
  localparam logic [10:0] M_Q = 11'h004;
  localparam logic [10:0] M_SNT = 11'h002;
  localparam logic [10:0] M_LOCK = 11'h001;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  rsq_rx_irq_s rx_irq = '0;
  logic freq_changed = 1'b0;
  rsq_state_e seq_state;
  logic relaunch;
  logic expiry;
  logic irq;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] q;

  // short tick lengths keep the timer scenario brief
  rsq_seq_rx #(.TICK2_CYC(23'h14), .TICK3_CYC(23'h28)) dut_u (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rx_irq(rx_irq), .freq_changed(freq_changed), .seq_state(seq_state),
    .reception_relaunch(relaunch), .first_timer_expiry(expiry), .irq(irq)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    sel <= 4'hf;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (n >= 16) begin
      bad_count++;
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // one-cycle event pulse; returns where the resulting state is visible
  task automatic ev(input logic [10:0] v);
    @(posedge clk);
    rx_irq <= rsq_rx_irq_s'(v);
    @(posedge clk);
    rx_irq <= '0;
    @(posedge clk);
  endtask : ev

  task automatic go(input logic [7:0] cfg, input logic [7:0] ctl);
    wb(1'b1, `RSQ_IDX_CTRL, 8'h40);
    wb(1'b1, `RSQ_IDX_RX_CFG, cfg);
    wb(1'b1, `RSQ_IDX_CTRL, ctl | 8'h80);
    repeat (2) @(posedge clk);
    chk(32'(seq_state), 32'(RSQ_RX));
  endtask : go

  task automatic t_regs();
    wb(1'b0, `RSQ_IDX_RX_CFG, 8'h00);
    chk(q, 32'h0);
    wb(1'b0, `RSQ_IDX_TIMER_RES, 8'h00);
    chk(q, 32'h0);
    wb(1'b0, `RSQ_IDX_T1_COEF, 8'h00);
    chk(q, 32'hf5);
    wb(1'b1, 6'h10, 8'h5a);
    wb(1'b0, 6'h10, 8'h00);
    chk(q, 32'h0);
    wb(1'b1, `RSQ_IDX_TIMER_RES, 8'hff);
    wb(1'b0, `RSQ_IDX_TIMER_RES, 8'h00);
    chk(q, 32'h0f);
    wb(1'b1, `RSQ_IDX_RX_CFG, 8'hdb);
    wb(1'b0, `RSQ_IDX_RX_CFG, 8'h00);
    chk(q, 32'hdb);
  endtask : t_regs

  task automatic t_rx_exit();
    logic [10:0] eb[7] = '{M_PAY, M_PAY, M_PAY, M_CRC, M_STR, M_SYN, M_PRE};
    logic [2:0] code[7] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    logic [7:0] ctl[7] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    rsq_state_e ex[7] = '{RSQ_PKT, RSQ_OFF, RSQ_IDLE, RSQ_PKT, RSQ_OFF, RSQ_OFF, RSQ_OFF};
    wb(1'b1, `RSQ_IDX_TIMER_RES, 8'h00);
    for (int i = 0; i < 7; i++) begin
      // packet exit 101 parks in the packet state so it can be seen
      go({code[i], 5'h05}, ctl[i]);
      ev(M_Q);
      chk(32'(seq_state), 32'(RSQ_RX));
      ev(eb[i]);
      chk(32'(seq_state), 32'(ex[i]));
    end
    go({3'h3, 2'h1, 3'h5}, 8'h00);
    ev(M_PAY);
    chk(32'(seq_state), 32'(RSQ_TX));
    ev(M_SNT);
    chk(32'(seq_state), 32'(RSQ_OFF));
    go({3'h3, 2'h1, 3'h5}, 8'h00);
    ev(M_PAY | M_CRC);
    chk(32'(seq_state), 32'(RSQ_PKT));
  endtask : t_rx_exit

  task automatic t_timeout();
    logic [10:0] tw[4] = '{M_SW, M_PW, M_YW, M_YW};
    rsq_state_e ex[4] = '{RSQ_RX, RSQ_TX, RSQ_OFF, RSQ_OFF};
    for (int i = 0; i < 4; i++) begin
      go({3'h4, 2'(i), 3'h5}, 8'h00);
      ev(M_PAY);
      chk(32'(seq_state), 32'(RSQ_RX));
      ev(tw[i]);
      chk(32'(relaunch), 32'(i == 0));
      chk(32'(seq_state), 32'(ex[i]));
    end
  endtask : t_timeout

  task automatic t_pkt();
    logic [2:0] pc[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4};
    rsq_state_e ex[6] = '{RSQ_OFF, RSQ_TX, RSQ_OFF, RSQ_FS, RSQ_RX, RSQ_RX};
    for (int i = 0; i < 6; i++) begin
      freq_changed <= (i == 3);
      go({3'h1, 2'h0, pc[i]}, 8'h00);
      ev(M_PAY);
      repeat (3) @(posedge clk);
      if (i == 1) begin
        chk(32'(seq_state), 32'(RSQ_PKT));
        ev(M_Q);
      end
      chk(32'(seq_state), 32'(ex[i]));
      if (i == 3) begin
        ev(M_LOCK);
        chk(32'(seq_state), 32'(RSQ_RX));
      end
    end
    freq_changed <= 1'b0;
  endtask : t_pkt

  task automatic t_timer();
    logic [7:0] res[3] = '{8'h04, 8'h08, 8'h00};
    logic [7:0] cf[3] = '{8'h01, 8'h03, 8'h02};
    int lim[3] = '{1281, 61, 0};
    logic [7:0] cl[3] = '{8'h06, 8'h04, 8'h06};
    rsq_state_e ex[3] = '{RSQ_RX, RSQ_TX, RSQ_IDLE};
    int n;
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `RSQ_IDX_TIMER_RES, res[i]);
      wb(1'b1, `RSQ_IDX_T1_COEF, cf[i]);
      go({3'h2, 2'h0, 3'h0}, cl[i]);
      ev(M_PAY);
      chk(32'(seq_state), 32'(RSQ_IDLE));
      n = 1;
      while (expiry !== 1'b1 && n < 1600) begin
        @(posedge clk);
        n++;
      end
      // one cycle of slack early and two cycles late for the pulse registering
      chk(32'((lim[i] == 0) ? (n == 1600) : (n >= lim[i] - 1 && n <= lim[i] + 2)), 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(seq_state), 32'(ex[i]));
    end
  endtask : t_timer

  task automatic t_irq();
    wb(1'b1, `RSQ_IDX_IRQ_MASK, 8'h02);
    go({3'h4, 2'h3, 3'h5}, 8'h00);
    wb(1'b0, `RSQ_IDX_IRQ_ST, 8'h00);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    ev(M_PW);
    chk(32'(seq_state), 32'(RSQ_OFF));
    chk(32'(irq), 32'h1);
    wb(1'b0, `RSQ_IDX_IRQ_ST, 8'h00);
    chk(q & 32'h2, 32'h2);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    wb(1'b0, `RSQ_IDX_IRQ_MASK, 8'h00);
    chk(q, 32'h02);
    wb(1'b0, `RSQ_IDX_STATE, 8'h00);
    chk(q, 32'(RSQ_OFF));
  endtask : t_irq

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_rx_exit();
    t_timeout();
    t_pkt();
    t_timer();
    t_irq();
    summarize();
  end

  // the whole run needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule : rsq_seq_rx_test
